// *** include/dio_pkg.sv ***
// Package of constants for the twenty-channel digital port.
// Assumes one 20 MHz clock and a simple strobe register port.
package dio_pkg;
  // -----------------------------------------------------------------
  // Geometry
  // -----------------------------------------------------------------
  localparam int unsigned NUM_CH = 20;
  localparam int unsigned NUM_SE = 8;
  localparam int unsigned NUM_DIFF = 12;
  localparam int unsigned SE_GROUP = 4;
  localparam int unsigned NUM_GROUPS = 2;
  localparam int unsigned QUEUE_DEPTH = 2048;
  localparam int unsigned QUEUE_AW = 11;
  localparam int unsigned TS_W = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_PS = 5000;
  localparam int unsigned CLK_PERIOD_PS = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int unsigned TICKS_PER_CLK = CLK_PERIOD_PS / TICK_PS;

  // -----------------------------------------------------------------
  // Register offsets (word index)
  // -----------------------------------------------------------------
  localparam logic [4:0] A_GROUP_DIR = 5'h00;
  localparam logic [4:0] A_BIT_DIR = 5'h01;
  localparam logic [4:0] A_INPUT = 5'h02;
  localparam logic [4:0] A_OUT_WORD = 5'h03;
  localparam logic [4:0] A_OUT_SET = 5'h04;
  localparam logic [4:0] A_OUT_CLR = 5'h05;
  localparam logic [4:0] A_EDGE_RISE = 5'h06;
  localparam logic [4:0] A_EDGE_FALL = 5'h07;
  localparam logic [4:0] A_FILTER = 5'h08;
  localparam logic [4:0] A_QCTRL = 5'h09;
  localparam logic [4:0] A_QSTAT = 5'h0A;
  localparam logic [4:0] A_QLEVEL = 5'h0B;
  localparam logic [4:0] A_QTIME = 5'h0C;
  localparam logic [4:0] A_QWR_LEVEL = 5'h0D;
  localparam logic [4:0] A_QWR_TIME = 5'h0E;
  localparam logic [4:0] A_TIMER = 5'h0F;
  localparam logic [4:0] A_IRQ_STAT = 5'h10;
  localparam logic [4:0] A_IRQ_MASK = 5'h11;
  localparam logic [4:0] A_BOOT = 5'h12;

  // Queue control bits
  localparam int unsigned QC_CAP_EN = 0;
  localparam int unsigned QC_OUT_EN = 1;
  localparam int unsigned QC_CLEAR = 2;
  localparam int unsigned QC_START = 3;
  // Queue status bits
  localparam int unsigned QS_FULL = 0;
  localparam int unsigned QS_EMPTY = 1;
  localparam int unsigned QS_RUN = 2;
  // Interrupt bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_EDGE = 0;
  localparam int unsigned IRQ_FULL = 1;
  localparam int unsigned IRQ_EMPTY = 2;
  // Filter field width
  localparam int unsigned FILT_W = 8;

  typedef enum logic [1:0] {Q_IDLE, Q_CAPTURE, Q_OUTPUT} queue_mode_t;
endpackage

// *** sim/dio_port_chk.sv ***
// Checker for the digital port, watching the top ports only.
// Assumes the bench binds it to every dio_port instance.
`timescale 1ns/1ps
`default_nettype none
module dio_port_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Pins and boot
  input wire logic [19:0] pin_o,
  input wire logic [19:0] pin_oe_b_o,
  input wire logic boot_present_i,
  input wire logic boot_start_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Edges since release; saturates so it never wraps back to zero
  logic [2:0] up_cnt;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Direction writes
  sequence grp_wr_s;
    wr_i && addr_i == dio_pkg::A_GROUP_DIR;
  endsequence
  sequence bit_wr_s;
    wr_i && addr_i == dio_pkg::A_BIT_DIR;
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  read_idle_a: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0) else $error("stray read data");
  quiet_start_a: assert property (
    up_cnt < 3'h3 |-> pin_oe_b_o == 20'hFFFFF && pin_o == 20'h0)
    else $error("driver on after reset");
  group_even_a: assert property (
    pin_oe_b_o[3:0] inside {4'h0, 4'hF} &&
    pin_oe_b_o[7:4] inside {4'h0, 4'hF}) else $error("group split");
  drive_mask_a: assert property (
    (pin_o & pin_oe_b_o) == 20'h0) else $error("level on input pin");
  dir_cause_a: assert property (
    $changed(pin_oe_b_o) |-> $past(wr_i && addr_i <= 5'h01))
    else $error("direction moved without write");
  group_write_a: assert property (
    grp_wr_s |=> pin_oe_b_o[7:0] ==
      {{4{!$past(wdata_i[1])}}, {4{!$past(wdata_i[0])}}})
    else $error("group direction wrong");
  bit_write_a: assert property (
    bit_wr_s |=> pin_oe_b_o[19:8] == ~$past(wdata_i[11:0]))
    else $error("bit direction wrong");
  boot_gate_a: assert property (
    !boot_present_i |-> !boot_start_o) else $error("boot without program");
  boot_run_a: assert property (
    up_cnt >= 3'h4 && boot_present_i |-> boot_start_o)
    else $error("boot not started");
endmodule
`default_nettype wire

// *** sim/dio_port_tb.sv ***
// Bench for the digital port: register table, then capture, filter,
// full queue and timed output. Assumes checker and line model.
`timescale 1ns/1ps
`default_nettype none
module dio_port_tb;
  // ---------------------------------------------------------------
  // Signals and tables
  // ---------------------------------------------------------------
  logic clock_i, rst_b_i, wr_i, rd_i, boot_present_i;
  logic boot_start_o, irq_o;
  logic [4:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rv, t0;
  logic [19:0] pin_i, pin_o, pin_oe_b_o, level, drive;
  int fail_count, tests_run, cyc;
  typedef struct {
    logic [4:0] wa;
    logic [31:0] wd;
    logic [4:0] ra;
    logic [31:0] re;
    logic [19:0] pe;
  } row_t;
  // Write, read-back place and value, pins; all channels start as out
  row_t rows [6] = '{
    '{5'h03, 32'hA5A5A, 5'h03, 32'hA5A5A, 20'hA5A5A},
    '{5'h04, 32'h00101, 5'h03, 32'hA5B5B, 20'hA5B5B},
    '{5'h05, 32'h0000A, 5'h03, 32'hA5B51, 20'hA5B51},
    '{5'h1F, 32'hFFFFFFFF, 5'h1F, 32'h0, 20'hA5B51},
    '{5'h00, 32'h1, 5'h03, 32'hA5B51, 20'hA5B01},
    '{5'h01, 32'h0F0, 5'h03, 32'hA5B51, 20'h05001}};
  logic [19:0] caps [3] = '{20'h00001, 20'h80003, 20'h80002};

  dio_port #(.DEPTH(16), .AW(4)) dut_u (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_b_o(pin_oe_b_o), .boot_present_i(boot_present_i),
    .boot_start_o(boot_start_o), .irq_o(irq_o));
  line_model lines_u (.clock_i(clock_i), .pin_o(pin_o),
    .pin_oe_b_o(pin_oe_b_o), .pin_i(pin_i), .level_i(level),
    .drive_i(drive));

  // Clock and hang guard
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One strobe cycle; read data caught mid-cycle after it
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(negedge clock_i);
    rv = rdata_o;
    @(posedge clock_i);
  endtask
  task automatic rc(string nm, logic [4:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  task automatic do_reset(logic boot);
    rst_b_i <= 1'b0;
    boot_present_i <= boot;
    tick(10);
    rst_b_i <= 1'b1;
    tick(4);
    @(negedge clock_i);
    chk("drivers off", 32'hFFFFF, {12'h0, pin_oe_b_o});
    chk("boot start", {31'h0, boot}, {31'h0, boot_start_o});
    @(posedge clock_i);
  endtask
  task automatic wait_pin(logic [19:0] v, int lim);
    repeat (lim) begin
      @(negedge clock_i);
      if (pin_o === v) break;
    end
    chk("pattern", {12'h0, v}, {12'h0, pin_o});
    @(posedge clock_i);
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 5'h00;
    wdata_i = 32'h0;
    level = 20'h0;
    drive = 20'h0;
    boot_present_i = 1'b1;
    do_reset(1'b1);
    rc("queue status", 5'h0A, 32'h2);
    drive <= 20'hFFFFF;
    bus(1'b1, 5'h00, 32'h3);
    bus(1'b1, 5'h01, 32'hFFF);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].wa, rows[i].wd);
      chk("pins", {12'h0, rows[i].pe}, {12'h0, pin_o});
      rc("read back", rows[i].ra, rows[i].re);
    end
    // Reset in mid-run drops every driver
    do_reset(1'b0);
    bus(1'b1, 5'h09, 32'h1);
    bus(1'b0, 5'h06, 32'h0);
    bus(1'b0, 5'h07, 32'h0);
    for (int i = 0; i < 3; i++) begin
      level <= caps[i];
      tick(5);
    end
    bus(1'b0, 5'h0A, 32'h0);
    chk("count", 32'd3, {20'h0, rv[27:16]});
    chk("irq masked", 32'h0, {31'h0, irq_o});
    bus(1'b1, 5'h11, 32'h7);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    for (int i = 0; i < 3; i++) begin
      rc("level", 5'h0B, {12'h0, caps[i]});
      bus(1'b0, 5'h0C, 32'h0);
      if (i > 0) chk("stamp step", 32'd50, rv - t0);
      t0 = rv;
    end
    rc("rising", 5'h06, 32'h80003);
    rc("falling", 5'h07, 32'h1);
    rc("rise cleared", 5'h06, 32'h0);
    bus(1'b0, 5'h10, 32'h0);
    chk("irq cause", 32'h1, {31'h0, rv[0]});
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    // Filter off: one-cycle spike is taken
    level <= 20'h80006;
    tick(1);
    level <= 20'h80002;
    tick(4);
    bus(1'b0, 5'h0A, 32'h0);
    chk("no filter", 32'd2, {20'h0, rv[27:16]});
    bus(1'b1, 5'h08, 32'h4);
    bus(1'b1, 5'h09, 32'h5);
    for (int i = 0; i < 2; i++) begin
      level <= 20'h80006;
      tick(2 + 8 * i);
      level <= 20'h80002;
      tick(10);
    end
    bus(1'b0, 5'h0A, 32'h0);
    chk("filtered", 32'd2, {20'h0, rv[27:16]});
    bus(1'b1, 5'h08, 32'h0);
    bus(1'b1, 5'h09, 32'h5);
    repeat (18) begin
      level[5] <= ~level[5];
      tick(2);
    end
    bus(1'b0, 5'h0A, 32'h0);
    chk("full", 32'h21, {19'h0, rv[27:16], rv[0]});
    bus(1'b0, 5'h10, 32'h0);
    chk("full irq", 32'h1, {31'h0, rv[1]});
    bus(1'b1, 5'h09, 32'h5);
    bus(1'b0, 5'h0A, 32'h0);
    chk("cleared", 32'h0, {19'h0, rv[27:16], rv[0]});
    // Timed output: load two pairs, hold, then start
    bus(1'b1, 5'h00, 32'h3);
    bus(1'b1, 5'h01, 32'hFFF);
    bus(1'b1, 5'h03, 32'h0);
    bus(1'b1, 5'h09, 32'h6);
    bus(1'b0, 5'h0F, 32'h0);
    t0 = rv;
    bus(1'b1, 5'h0D, 32'h12345);
    bus(1'b1, 5'h0E, t0 + 32'd400);
    bus(1'b1, 5'h0D, 32'hABCDE);
    bus(1'b1, 5'h0E, t0 + 32'd600);
    bus(1'b0, 5'h0A, 32'h0);
    chk("loaded", 32'h0, {31'h0, rv[1]});
    tick(40);
    chk("held", 32'h0, {12'h0, pin_o});
    bus(1'b1, 5'h09, 32'hA);
    wait_pin(20'h12345, 6);
    wait_pin(20'hABCDE, 30);
    bus(1'b0, 5'h0F, 32'h0);
    chk("on time", 32'h1, {31'h0, rv - t0 - 32'd600 <= 32'd60});
    bus(1'b0, 5'h0A, 32'h0);
    chk("drained", 32'h1, {31'h0, rv[1]});
    chk("drain irq", 32'h1, {31'h0, irq_o});
    bus(1'b0, 5'h10, 32'h0);
    chk("drain cause", 32'h1, {31'h0, rv[2]});
    give_verdict();
  end
endmodule

bind dio_port dio_port_chk chk_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pin_o(pin_o), .pin_oe_b_o(pin_oe_b_o),
  .boot_present_i(boot_present_i), .boot_start_o(boot_start_o));
`default_nettype wire

// *** sim/line_model.sv ***
// Far-side signal lines: loop driven pins back, else bench levels.
// Assumes the bench gives a level and a drive flag per channel.
`timescale 1ns/1ps
`default_nettype none
module line_model (
  // Clock
  input wire logic clock_i,
  // Port side
  input wire logic [19:0] pin_o,
  input wire logic [19:0] pin_oe_b_o,
  output logic [19:0] pin_i,
  // Bench side
  input wire logic [19:0] level_i,
  input wire logic [19:0] drive_i
);
  logic [11:0] last_reg = 12'h000;
  logic [19:0] idle;
  // Loose pairs flip each cycle so a stale level never passes
  always_ff @(posedge clock_i) last_reg <= ~pin_i[19:8];
  // Single-ended lines have pull-downs
  assign idle = {last_reg, 8'h00};
  // Wire level from the port's enable first, then the bench
  always_comb begin
    for (int k = 0; k < 20; k++) begin
      if (!pin_oe_b_o[k]) pin_i[k] = pin_o[k];
      else if (drive_i[k]) pin_i[k] = level_i[k];
      else pin_i[k] = idle[k];
    end
  end
endmodule
`default_nettype wire

// *** src/dio_port.sv ***
// Twenty-channel digital port with edge capture and timed output.
// Assumes one 20 MHz clock; register port used by processor or host.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - Twenty channels: eight single-ended, twelve differential, each in or out.
// RULE2 - Single-ended direction set per group of four channels.
// RULE3 - Each differential channel has its own direction bit.
// RULE4 - After reset every channel is an input, no driver enabled.
// RULE5 - Edge monitor samples inputs for changes when enabled.
// RULE6 - Each change pushes levels plus time stamp; queue holds 2048.
// RULE7 - Captured entries are read out in capture order.
// RULE8 - Rising and falling edges per input are recorded and readable.
// RULE9 - Each input has its own filter; one shared setting.
// RULE10 - Filters stay disabled after reset until configured.
// RULE11 - Timed output buffers 2048 pattern/time pairs, runs on its own.
// RULE12 - Scheduled instants resolve to 5 ns ticks; timer steps 10 ticks (50 ns) per clock.
// RULE13 - One queue serves capture or output, never both.
// RULE14 - Embedded processor reads and writes every channel.
// RULE15 - Stored boot program is loaded and started at power-up.
// RULE16 - Capture queue has full flag and clear command.
// RULE17 - Output queue has empty flag and waits for start.
// RULE18 - Output bits set or cleared singly; word reads back.
module dio_port #(
  parameter int unsigned DEPTH = dio_pkg::QUEUE_DEPTH,
  parameter int unsigned AW = dio_pkg::QUEUE_AW
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [dio_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dio_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [dio_pkg::DATA_W-1:0] rdata_o,
  // Channel pins (oe low means driving)
  input wire logic [dio_pkg::NUM_CH-1:0] pin_i,
  output logic [dio_pkg::NUM_CH-1:0] pin_o,
  output logic [dio_pkg::NUM_CH-1:0] pin_oe_b_o,
  // Boot store
  input wire logic boot_present_i,
  output logic boot_start_o,
  // Interrupt
  output logic irq_o
);
  localparam int unsigned N = dio_pkg::NUM_CH;
  localparam int unsigned TW = dio_pkg::TS_W;

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  logic rst_meta_reg, rst_sync_reg;
  // Two flops so the release is clean against clock_i
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_n = rst_sync_reg;

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  wire logic wr_hit [0:18];
  genvar a;
  generate
    for (a = 0; a <= 18; a++) begin : g_dec
      assign wr_hit[a] = wr_i && (addr_i == 5'(a));
    end
  endgenerate

  // -----------------------------------------------------------------
  // Direction
  // -----------------------------------------------------------------
  logic [dio_pkg::NUM_GROUPS-1:0] group_direction_config_reg;
  logic [dio_pkg::NUM_DIFF-1:0] per_bit_direction_config_reg;
  logic [N-1:0] dir_out;
  // RULE4 all inputs
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      group_direction_config_reg <= '0;
      per_bit_direction_config_reg <= '0;
    end else begin
      if (wr_hit[dio_pkg::A_GROUP_DIR]) begin
        group_direction_config_reg <= wdata_i[dio_pkg::NUM_GROUPS-1:0];
      end
      if (wr_hit[dio_pkg::A_BIT_DIR]) begin
        per_bit_direction_config_reg <= wdata_i[dio_pkg::NUM_DIFF-1:0];
      end
    end
  end
  genvar c;
  generate
    for (c = 0; c < N; c++) begin : g_dir
      if (c < dio_pkg::NUM_SE) begin : g_se
        // RULE2 group of four
        assign dir_out[c] = group_direction_config_reg[c/dio_pkg::SE_GROUP];
      end else begin : g_df
        // RULE3 per bit direction
        assign dir_out[c] = per_bit_direction_config_reg[c-dio_pkg::NUM_SE];
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Filter and edges
  // -----------------------------------------------------------------
  logic [dio_pkg::FILT_W-1:0] filter_reg;
  logic [N-1:0] clean, prev_reg, rise_reg, fall_reg;
  // RULE10 zero disables
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      filter_reg <= '0;
    end else if (wr_hit[dio_pkg::A_FILTER]) begin
      filter_reg <= wdata_i[dio_pkg::FILT_W-1:0];
    end
  end
  // RULE9 shared setting
  spike_filter #(.W(N), .FW(dio_pkg::FILT_W)) u_filter (
    .clock_i(clock_i),
    .rst_b_i(rst_n),
    .length_i(filter_reg),
    .raw_i(pin_i),
    .clean_o(clean)
  );
  wire logic [N-1:0] inmask = ~dir_out;
  wire logic [N-1:0] changed = (clean ^ prev_reg) & inmask;
  wire logic rd_rise = rd_i && addr_i == dio_pkg::A_EDGE_RISE;
  wire logic rd_fall = rd_i && addr_i == dio_pkg::A_EDGE_FALL;
  // RULE8 sticky edges, set beats read clear
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
    end else begin
      prev_reg <= clean;
      rise_reg <= (rd_rise ? '0 : rise_reg) | (changed & clean);
      fall_reg <= (rd_fall ? '0 : fall_reg) | (changed & ~clean);
    end
  end

  // -----------------------------------------------------------------
  // Time base in 5 ns ticks
  // -----------------------------------------------------------------
  logic [TW-1:0] timer_reg;
  // RULE12 5 ns resolution; hardware steps by clock period in ticks
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + TW'(dio_pkg::TICKS_PER_CLK);
    end
  end

  // -----------------------------------------------------------------
  // Shared queue
  // -----------------------------------------------------------------
  logic [N-1:0] lvl_mem [0:DEPTH-1];
  logic [TW-1:0] ts_mem [0:DEPTH-1];
  logic [AW:0] wp_reg, rp_reg;
  dio_pkg::queue_mode_t mode_reg;
  logic run_reg, stage_valid_reg;
  logic [N-1:0] wr_level_reg;
  logic [N-1:0] head_lvl_reg;
  logic [TW-1:0] head_ts_reg;
  wire logic [AW:0] count = wp_reg - rp_reg;
  wire logic q_full = count == (AW+1)'(DEPTH);
  wire logic q_empty = count == '0;
  wire logic [N-1:0] hd_lvl = lvl_mem[rp_reg[AW-1:0]];
  wire logic [TW-1:0] hd_ts = ts_mem[rp_reg[AW-1:0]];
  wire logic ctl_wr = wr_hit[dio_pkg::A_QCTRL];
  wire logic q_clear = ctl_wr && wdata_i[dio_pkg::QC_CLEAR];
  // RULE5 RULE6 capture on change
  wire logic cap_push = mode_reg == dio_pkg::Q_CAPTURE && |changed
    && !q_full;
  wire logic out_push = mode_reg == dio_pkg::Q_OUTPUT
    && wr_hit[dio_pkg::A_QWR_TIME] && !q_full;
  // RULE7 reading the time word pops one entry
  wire logic cap_pop = mode_reg == dio_pkg::Q_CAPTURE && !q_empty
    && rd_i && addr_i == dio_pkg::A_QTIME;
  // RULE11 pattern leaves once its time is reached
  wire logic out_pop = mode_reg == dio_pkg::Q_OUTPUT && run_reg
    && !q_empty && $signed(timer_reg - hd_ts) >= 0;

  // Mode: enabling one use disables the other
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= dio_pkg::Q_IDLE;
    end else if (ctl_wr) begin
      // RULE13 one use at a time
      case ({wdata_i[dio_pkg::QC_OUT_EN], wdata_i[dio_pkg::QC_CAP_EN]})
        2'h1: mode_reg <= dio_pkg::Q_CAPTURE;
        2'h2: mode_reg <= dio_pkg::Q_OUTPUT;
        default: mode_reg <= dio_pkg::Q_IDLE;
      endcase
    end
  end

  // Pointers
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (q_clear) begin
      // RULE16 clear drops all entries
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (cap_push || out_push) begin
        wp_reg <= wp_reg + (AW+1)'(1);
      end
      if (cap_pop || out_pop) begin
        rp_reg <= rp_reg + (AW+1)'(1);
      end
    end
  end

  // Storage write
  always_ff @(posedge clock_i) begin
    if (cap_push) begin
      lvl_mem[wp_reg[AW-1:0]] <= clean;
      ts_mem[wp_reg[AW-1:0]] <= timer_reg;
    end else if (out_push) begin
      lvl_mem[wp_reg[AW-1:0]] <= wr_level_reg;
      ts_mem[wp_reg[AW-1:0]] <= wdata_i;
    end
  end

  // Staged pattern word and head latch for reading
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_level_reg <= '0;
      head_lvl_reg <= '0;
      head_ts_reg <= '0;
      stage_valid_reg <= 1'b0;
    end else begin
      if (wr_hit[dio_pkg::A_QWR_LEVEL]) begin
        wr_level_reg <= wdata_i[N-1:0];
      end
      // Level read latches head so the pair stays coherent
      if (rd_i && addr_i == dio_pkg::A_QLEVEL) begin
        head_lvl_reg <= hd_lvl;
        head_ts_reg <= hd_ts;
        stage_valid_reg <= !q_empty;
      end else if ((rd_i && addr_i == dio_pkg::A_QTIME) || q_clear) begin
        // Latch is used once, so a lone time read sees the live head
        stage_valid_reg <= 1'b0;
      end
    end
  end

  // RULE17 start command arms output
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
    end else if (q_clear || mode_reg != dio_pkg::Q_OUTPUT) begin
      run_reg <= 1'b0;
    end else if (ctl_wr && wdata_i[dio_pkg::QC_START]) begin
      run_reg <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Output word
  // -----------------------------------------------------------------
  logic [N-1:0] out_reg;
  // RULE14 RULE18 word, set and clear
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
    end else if (out_pop) begin
      out_reg <= hd_lvl;
    end else if (wr_hit[dio_pkg::A_OUT_WORD]) begin
      out_reg <= wdata_i[N-1:0];
    end else if (wr_hit[dio_pkg::A_OUT_SET]) begin
      out_reg <= out_reg | wdata_i[N-1:0];
    end else if (wr_hit[dio_pkg::A_OUT_CLR]) begin
      out_reg <= out_reg & ~wdata_i[N-1:0];
    end
  end
  // RULE1 drive only output channels
  assign pin_o = out_reg & dir_out;
  assign pin_oe_b_o = ~dir_out;

  // -----------------------------------------------------------------
  // Boot start
  // -----------------------------------------------------------------
  logic boot_done_reg, boot_start_reg;
  // RULE15 strap caught after reset release
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_done_reg <= 1'b0;
      boot_start_reg <= 1'b0;
    end else if (!boot_done_reg) begin
      boot_done_reg <= 1'b1;
      boot_start_reg <= boot_present_i;
    end
  end
  assign boot_start_o = boot_start_reg;

  // -----------------------------------------------------------------
  // Interrupts
  // -----------------------------------------------------------------
  logic [dio_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
  assign irq_ev[dio_pkg::IRQ_EDGE] = cap_push;
  assign irq_ev[dio_pkg::IRQ_FULL] = cap_push && !cap_pop
    && count == (AW+1)'(DEPTH - 1);
  assign irq_ev[dio_pkg::IRQ_EMPTY] = out_pop && !out_push
    && count == (AW+1)'(1);
  wire logic rd_irq = rd_i && addr_i == dio_pkg::A_IRQ_STAT;
  // Read clears; a new event in the same cycle survives
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      irq_stat_reg <= (rd_irq ? '0 : irq_stat_reg) | irq_ev;
      if (wr_hit[dio_pkg::A_IRQ_MASK]) begin
        irq_mask_reg <= wdata_i[dio_pkg::IRQ_W-1:0];
      end
    end
  end
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // -----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // -----------------------------------------------------------------
  logic [dio_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (addr_i)
      dio_pkg::A_GROUP_DIR: rd_mux[dio_pkg::NUM_GROUPS-1:0] =
        group_direction_config_reg;
      dio_pkg::A_BIT_DIR: rd_mux[dio_pkg::NUM_DIFF-1:0] =
        per_bit_direction_config_reg;
      dio_pkg::A_INPUT: rd_mux[N-1:0] = clean;
      dio_pkg::A_OUT_WORD: rd_mux[N-1:0] = out_reg;
      dio_pkg::A_EDGE_RISE: rd_mux[N-1:0] = rise_reg;
      dio_pkg::A_EDGE_FALL: rd_mux[N-1:0] = fall_reg;
      dio_pkg::A_FILTER: rd_mux[dio_pkg::FILT_W-1:0] = filter_reg;
      dio_pkg::A_QCTRL: begin
        rd_mux[dio_pkg::QC_CAP_EN] = mode_reg == dio_pkg::Q_CAPTURE;
        rd_mux[dio_pkg::QC_OUT_EN] = mode_reg == dio_pkg::Q_OUTPUT;
      end
      dio_pkg::A_QSTAT: begin
        rd_mux[dio_pkg::QS_FULL] = q_full;
        rd_mux[dio_pkg::QS_EMPTY] = q_empty;
        rd_mux[dio_pkg::QS_RUN] = run_reg;
        rd_mux[16 +: AW+1] = count;
      end
      dio_pkg::A_QLEVEL: rd_mux[N-1:0] = hd_lvl;
      dio_pkg::A_QTIME: rd_mux = stage_valid_reg ? head_ts_reg : hd_ts;
      dio_pkg::A_QWR_LEVEL: rd_mux[N-1:0] = wr_level_reg;
      dio_pkg::A_TIMER: rd_mux = timer_reg;
      dio_pkg::A_IRQ_STAT: rd_mux[dio_pkg::IRQ_W-1:0] = irq_stat_reg;
      dio_pkg::A_IRQ_MASK: rd_mux[dio_pkg::IRQ_W-1:0] = irq_mask_reg;
      dio_pkg::A_BOOT: rd_mux[0] = boot_start_reg;
      default: rd_mux = '0;
    endcase
  end
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= '0;
    end
  end
endmodule
`default_nettype wire

// *** src/spike_filter.sv ***
// One spike filter per input channel, shared length setting.
// Assumes inputs synchronous to clock_i; length zero disables it.
`timescale 1ns/1ps
`default_nettype none
module spike_filter #(
  parameter int unsigned W = dio_pkg::NUM_CH,
  parameter int unsigned FW = dio_pkg::FILT_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [FW-1:0] length_i,
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] clean_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_ch
      logic [FW-1:0] cnt_reg;
      logic out_reg;
      // Level must stay for length cycles before it is passed on
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          cnt_reg <= '0;
          out_reg <= 1'b0;
        end else if (length_i == '0 || raw_i[g] == out_reg) begin
          cnt_reg <= '0;
          out_reg <= raw_i[g];
        end else if (cnt_reg >= length_i - FW'(1)) begin
          cnt_reg <= '0;
          out_reg <= raw_i[g];
        end else begin
          cnt_reg <= cnt_reg + FW'(1);
        end
      end
      assign clean_o[g] = out_reg;
    end
  endgenerate
endmodule
`default_nettype wire
